/* File: hdl/erc_cfg_lock.sv */
// One-time configuration lock of the external regulator
module erc_cfg_lock
(
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic ce_i,
    input wire logic wr_i,
    input wire logic en_i,
    input wire logic ls_i,
    output erc_pkg::erc_cfg_t cfg_o,
    output logic err_o
);
    erc_pkg::erc_cfg_t cfg_reg;
    erc_pkg::erc_cfg_t cfg_next;

    // Only power-on reset touches this state; soft reset is not wired in
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            cfg_reg <= erc_pkg::CFG_NONE;
        else if (ce_i)
            cfg_reg <= cfg_next; // see [RULE18]
    end

    always_comb
    begin
        cfg_next = cfg_reg;
        err_o = 1'b0;
        case (cfg_reg)
            erc_pkg::CFG_NONE:
            begin
                if (wr_i && ls_i)
                    cfg_next = erc_pkg::CFG_SHARE; // see [RULE6]
                else if (wr_i && en_i)
                    cfg_next = erc_pkg::CFG_ALONE; // see [RULE1]
            end
            // Change attempts are silently dropped here
            erc_pkg::CFG_ALONE: cfg_next = erc_pkg::CFG_ALONE; // see [RULE2]
            erc_pkg::CFG_SHARE:
                err_o = ce_i && wr_i && (!ls_i || en_i); // see [RULE7]
            default: cfg_next = erc_pkg::CFG_NONE;
        endcase
    end

    assign cfg_o = cfg_reg;
endmodule

/* File: hdl/erc_pkg.sv */
// Constants, types and register map of the external regulator control block
package erc_pkg;

    // ****************************************
    // Register map (byte addresses)
    // ****************************************
    localparam int unsigned ADDR_W = 4;
    localparam logic [3:0] OFF_CTRL = 4'h0;
    localparam logic [3:0] OFF_STAT = 4'h4;
    localparam logic [3:0] OFF_IRQ = 4'h8;
    localparam logic [3:0] OFF_MASK = 4'hc;

    // ****************************************
    // Control register fields
    // ****************************************
    localparam int unsigned CTRL_W = 5;
    localparam int unsigned CTRL_EN = 0;
    localparam int unsigned CTRL_LS = 1;
    localparam int unsigned CTRL_STP = 2;
    localparam int unsigned CTRL_VSEL = 3;
    localparam int unsigned CTRL_KEEP = 4;
    localparam logic [4:0] CTRL_RST = 5'h00;

    // ****************************************
    // Status register fields
    // ****************************************
    localparam int unsigned STAT_CFG = 0;
    localparam int unsigned STAT_ON = 2;
    localparam int unsigned STAT_FLG = 3;
    localparam int unsigned STAT_ILIM = 6;

    // ****************************************
    // Event bits, shared by flags, irq status and mask
    // ****************************************
    localparam int unsigned EV_W = 3;
    localparam int unsigned EV_ERR = 0;
    localparam int unsigned EV_OC = 1;
    localparam int unsigned EV_UV = 2;
    localparam logic [2:0] EV_RST = 3'h0;

    // Configuration lock, Gray coded along both paths out of none
    typedef enum logic [1:0] {
        CFG_NONE = 2'h0,
        CFG_ALONE = 2'h1,
        CFG_SHARE = 2'h2
    } erc_cfg_t;

    typedef enum logic [2:0] {
        MODE_INIT = 3'h0,
        MODE_NORMAL = 3'h1,
        MODE_STOP = 3'h2,
        MODE_SLEEP = 3'h3,
        MODE_RESTART = 3'h4,
        MODE_FAILSAFE = 3'h5
    } erc_mode_t;

    typedef struct packed {
        logic shunt_lim;
        logic ext_uv;
        logic supply_uv;
    } erc_sense_t;

    typedef struct packed {
        logic reg_on;
        logic cur_limit;
        logic sel_3v3;
    } erc_drive_t;

endpackage

/* File: hdl/erc_sticky.sv */
// Vector of sticky flags, set wins over clear, clear may be held off
module erc_sticky
#(
    parameter int unsigned W = 3
)
(
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic ce_i,
    input wire logic soft_i,
    input wire logic [W-1:0] set_i,
    input wire logic [W-1:0] clr_i,
    input wire logic [W-1:0] hold_i,
    output logic [W-1:0] q_o
);
    logic [W-1:0] q_reg;

    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            q_reg <= '0;
        else if (ce_i && soft_i)
            q_reg <= set_i;
        else if (ce_i)
            q_reg <= set_i | (q_reg & ~(clr_i & ~hold_i));
    end

    assign q_o = q_reg;
endmodule

/* File: hdl/erc_top.sv */
// External regulator control: config lock, mode gating, flags, Wishbone slave
//
// Notes on behaviour
// [RULE1] Enable with select clear locks stand-alone
// [RULE2] Stand-alone change attempts ignored, no error
// [RULE3] Stand-alone shunt threshold limits, sets overcurrent
// [RULE4] Overcurrent clear only after condition gone
// [RULE5] Stand-alone undervoltage sets undervoltage flag
// [RULE6] First select locks sharing, enable ignored
// [RULE7] Sharing change attempts set command error
// [RULE8] Sharing off in stop unless share-in-stop
// [RULE9] Sharing resumes on return to normal
// [RULE10] Share-in-stop keeps sharing on in stop
// [RULE11] No undervoltage reporting while sharing
// [RULE12] Sharing switches off in fail-safe mode
// [RULE13] No overcurrent flag while sharing
// [RULE14] Software sets matching output voltage
// [RULE15] Software leaves unused regulator disabled
// [RULE16] Voltage select acts only in stand-alone
// [RULE17] Off below supply undervoltage unless keep-on
// [RULE18] Lock survives soft reset, cleared at power-up
module erc_top
(
    input wire logic ref_clk_i,
    input wire logic reset_n_i,
    input wire logic ce_i,
    input wire logic soft_reset_i,
    input erc_pkg::erc_mode_t mode_i,
    input erc_pkg::erc_sense_t sense_i,
    output erc_pkg::erc_drive_t drive_o,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [erc_pkg::ADDR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic irq_o
);

    // ****************************************
    // Declarations
    // ****************************************
    logic ack_reg;
    logic [31:0] rdat_reg;
    logic [31:0] rdat_next;
    logic [erc_pkg::CTRL_W-1:0] ctrl_reg;
    logic [erc_pkg::EV_W-1:0] mask_reg;
    logic acc;
    logic wr_ctrl;
    logic wr_stat;
    logic wr_mask;
    logic rd_irq;
    erc_pkg::erc_cfg_t cfg;
    logic cmd_err;
    logic [erc_pkg::EV_W-1:0] flag_set;
    logic [erc_pkg::EV_W-1:0] flag_clr;
    logic [erc_pkg::EV_W-1:0] flag_hold;
    logic [erc_pkg::EV_W-1:0] flags;
    logic [erc_pkg::EV_W-1:0] irq_ev;
    logic [erc_pkg::EV_W-1:0] irq_clr;
    logic [erc_pkg::EV_W-1:0] irq_stat;
    erc_pkg::erc_drive_t drive_reg;
    erc_pkg::erc_drive_t drive_next;
    logic en_bit;
    logic stp_bit;
    logic vsel_bit;
    logic keep_bit;
    logic mode_alive;
    logic share_mode_on;

    // ****************************************
    // Bus decode
    // ****************************************
    function automatic logic hit(input logic [erc_pkg::ADDR_W-1:0] adr,
                                 input logic [3:0] off);
        hit = (adr == off);
    endfunction

    // A request is taken once; ack in the next cycle then drops
    assign acc = wb_cyc_i && wb_stb_i && !ack_reg;
    assign wr_ctrl = acc && wb_we_i && wb_sel_i[0] && hit(wb_adr_i, erc_pkg::OFF_CTRL);
    assign wr_stat = acc && wb_we_i && wb_sel_i[0] && hit(wb_adr_i, erc_pkg::OFF_STAT);
    assign wr_mask = acc && wb_we_i && wb_sel_i[0] && hit(wb_adr_i, erc_pkg::OFF_MASK);
    assign rd_irq = acc && !wb_we_i && hit(wb_adr_i, erc_pkg::OFF_IRQ);

    always_ff @(posedge ref_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            ack_reg <= 1'b0;
        else if (ce_i)
            ack_reg <= acc;
    end

    assign wb_ack_o = ack_reg;

    // ****************************************
    // Control and mask registers
    // ****************************************
    always_ff @(posedge ref_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            ctrl_reg <= erc_pkg::CTRL_RST;
        else if (ce_i && soft_reset_i)
            ctrl_reg <= erc_pkg::CTRL_RST;
        else if (ce_i && wr_ctrl)
            ctrl_reg <= wb_dat_i[erc_pkg::CTRL_W-1:0];
    end

    always_ff @(posedge ref_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            mask_reg <= erc_pkg::EV_RST;
        else if (ce_i && soft_reset_i)
            mask_reg <= erc_pkg::EV_RST;
        else if (ce_i && wr_mask)
            mask_reg <= wb_dat_i[erc_pkg::EV_W-1:0];
    end

    assign en_bit = ctrl_reg[erc_pkg::CTRL_EN];
    assign stp_bit = ctrl_reg[erc_pkg::CTRL_STP];
    assign vsel_bit = ctrl_reg[erc_pkg::CTRL_VSEL];
    assign keep_bit = ctrl_reg[erc_pkg::CTRL_KEEP];

    // ****************************************
    // Configuration lock
    // ****************************************
    erc_cfg_lock u_lock
    (
        .clk_i(ref_clk_i),
        .reset_n_i(reset_n_i),
        .ce_i(ce_i),
        .wr_i(wr_ctrl),
        .en_i(wb_dat_i[erc_pkg::CTRL_EN]),
        .ls_i(wb_dat_i[erc_pkg::CTRL_LS]),
        .cfg_o(cfg),
        .err_o(cmd_err)
    );

    // ****************************************
    // Regulator drive
    // ****************************************
    // Stand-alone keeps its state in every mode except init and fail-safe
    assign mode_alive = (mode_i != erc_pkg::MODE_INIT) && (mode_i != erc_pkg::MODE_FAILSAFE);

    // Select bit is not consulted, so returning to normal re-enables by itself
    assign share_mode_on = (mode_i == erc_pkg::MODE_NORMAL) || // see [RULE9]
                           ((mode_i == erc_pkg::MODE_STOP) && stp_bit); // see [RULE8] [RULE10]

    always_comb
    begin
        drive_next = '0;
        case (cfg)
            erc_pkg::CFG_ALONE:
            begin
                drive_next.reg_on = en_bit && mode_alive;
                drive_next.cur_limit = sense_i.shunt_lim; // see [RULE3]
                drive_next.sel_3v3 = vsel_bit; // see [RULE16]
            end
            // Enable bit and voltage select play no part here
            erc_pkg::CFG_SHARE: drive_next.reg_on = share_mode_on; // see [RULE6] [RULE12]
            erc_pkg::CFG_NONE: drive_next = '0;
            default: drive_next = '0;
        endcase
        if (sense_i.supply_uv && !keep_bit)
            drive_next.reg_on = 1'b0; // see [RULE17]
    end

    always_ff @(posedge ref_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            drive_reg <= '0;
        else if (ce_i)
            drive_reg <= drive_next;
    end

    assign drive_o = drive_reg;

    // ****************************************
    // Status flags
    // ****************************************
    always_comb
    begin
        flag_set = '0;
        flag_set[erc_pkg::EV_ERR] = cmd_err;
        flag_set[erc_pkg::EV_OC] = (cfg == erc_pkg::CFG_ALONE) && // see [RULE3] [RULE13]
                                   sense_i.shunt_lim;
        flag_set[erc_pkg::EV_UV] = (cfg == erc_pkg::CFG_ALONE) && // see [RULE5] [RULE11]
                                   drive_reg.reg_on && sense_i.ext_uv;
        flag_clr = wr_stat ? wb_dat_i[erc_pkg::STAT_FLG +: erc_pkg::EV_W] : '0;
        flag_hold = '0;
        // A clear is refused while the shunt is still at threshold
        flag_hold[erc_pkg::EV_OC] = sense_i.shunt_lim; // see [RULE4]
    end

    erc_sticky #(.W(erc_pkg::EV_W)) u_flags
    (
        .clk_i(ref_clk_i),
        .reset_n_i(reset_n_i),
        .ce_i(ce_i),
        .soft_i(soft_reset_i),
        .set_i(flag_set),
        .clr_i(flag_clr),
        .hold_i(flag_hold),
        .q_o(flags)
    );

    // ****************************************
    // Interrupt status, cleared by reading it
    // ****************************************
    assign irq_ev = flag_set & ~flags;
    assign irq_clr = rd_irq ? {erc_pkg::EV_W{1'b1}} : '0;

    erc_sticky #(.W(erc_pkg::EV_W)) u_irq
    (
        .clk_i(ref_clk_i),
        .reset_n_i(reset_n_i),
        .ce_i(ce_i),
        .soft_i(soft_reset_i),
        .set_i(irq_ev),
        .clr_i(irq_clr),
        .hold_i('0),
        .q_o(irq_stat)
    );

    assign irq_o = |(irq_stat & mask_reg);

    // ****************************************
    // Read data
    // ****************************************
    always_comb
    begin
        rdat_next = '0;
        if (hit(wb_adr_i, erc_pkg::OFF_CTRL))
        begin
            rdat_next[erc_pkg::CTRL_W-1:0] = ctrl_reg;
            rdat_next[erc_pkg::CTRL_LS] = (cfg == erc_pkg::CFG_SHARE);
        end
        else if (hit(wb_adr_i, erc_pkg::OFF_STAT))
        begin
            rdat_next[erc_pkg::STAT_CFG +: 2] = cfg;
            rdat_next[erc_pkg::STAT_ON] = drive_reg.reg_on;
            rdat_next[erc_pkg::STAT_FLG +: erc_pkg::EV_W] = flags;
            rdat_next[erc_pkg::STAT_ILIM] = drive_reg.cur_limit;
        end
        else if (hit(wb_adr_i, erc_pkg::OFF_IRQ))
            rdat_next[erc_pkg::EV_W-1:0] = irq_stat;
        else if (hit(wb_adr_i, erc_pkg::OFF_MASK))
            rdat_next[erc_pkg::EV_W-1:0] = mask_reg;
    end

    always_ff @(posedge ref_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            rdat_reg <= '0;
        else if (ce_i && acc && !wb_we_i)
            rdat_reg <= rdat_next;
    end

    assign wb_dat_o = rdat_reg;

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!reset_n_i);

    // A change attempt is select cleared or enable set
    sequence s_share_bad_wr;
        ce_i && !soft_reset_i && wr_ctrl && (cfg == erc_pkg::CFG_SHARE) &&
            (!wb_dat_i[erc_pkg::CTRL_LS] || wb_dat_i[erc_pkg::CTRL_EN]);
    endsequence

    sequence s_err_raised;
        flags[erc_pkg::EV_ERR] && (cfg == erc_pkg::CFG_SHARE);
    endsequence

    sequence s_lock_share_wr;
        ce_i && wr_ctrl && (cfg == erc_pkg::CFG_NONE) && wb_dat_i[erc_pkg::CTRL_LS];
    endsequence

    sequence s_lock_alone_wr;
        ce_i && wr_ctrl && (cfg == erc_pkg::CFG_NONE) && !wb_dat_i[erc_pkg::CTRL_LS] &&
            wb_dat_i[erc_pkg::CTRL_EN];
    endsequence

    chk_share_cmd_err: assert property (s_share_bad_wr |=> s_err_raised) // see [RULE7]
        else $error("sharing change did not raise command error");

    chk_alone_no_err: assert property (ce_i && (cfg == erc_pkg::CFG_ALONE) && // see [RULE2]
        !wr_stat && !soft_reset_i |=> flags[erc_pkg::EV_ERR] == $past(flags[erc_pkg::EV_ERR]))
        else $error("stand-alone change touched command error");

    chk_lock_stable: assert property (cfg != erc_pkg::CFG_NONE |=> $stable(cfg)) // see [RULE1]
        else $error("locked configuration changed");

    chk_share_no_oc: assert property (cfg == erc_pkg::CFG_SHARE |-> // see [RULE13]
        !flags[erc_pkg::EV_OC] && !drive_reg.cur_limit)
        else $error("overcurrent reported while sharing");

    chk_share_no_uv: assert property (cfg == erc_pkg::CFG_SHARE |-> // see [RULE11]
        !flags[erc_pkg::EV_UV])
        else $error("undervoltage reported while sharing");

    chk_oc_sets: assert property (ce_i && (cfg == erc_pkg::CFG_ALONE) && // see [RULE3]
        sense_i.shunt_lim |=> flags[erc_pkg::EV_OC] && drive_reg.cur_limit)
        else $error("overcurrent not flagged");

    chk_oc_clr_held: assert property (ce_i && !soft_reset_i && // see [RULE4]
        flags[erc_pkg::EV_OC] && sense_i.shunt_lim |=> flags[erc_pkg::EV_OC])
        else $error("overcurrent cleared while present");

    chk_stop_share_off: assert property (ce_i && (cfg == erc_pkg::CFG_SHARE) && // see [RULE8]
        (mode_i == erc_pkg::MODE_STOP) && !stp_bit |=> !drive_reg.reg_on)
        else $error("sharing active in stop without enable");

    chk_share_resume: assert property (ce_i && (cfg == erc_pkg::CFG_SHARE) && // see [RULE9]
        (mode_i == erc_pkg::MODE_NORMAL) && !sense_i.supply_uv |=> drive_reg.reg_on)
        else $error("sharing did not resume in normal mode");

    chk_failsafe_off: assert property (ce_i && (cfg == erc_pkg::CFG_SHARE) && // see [RULE12]
        (mode_i == erc_pkg::MODE_FAILSAFE) |=> !drive_reg.reg_on)
        else $error("regulator on in fail-safe while sharing");

    chk_supply_uv_off: assert property (ce_i && sense_i.supply_uv && !keep_bit // see [RULE17]
        |=> !drive_reg.reg_on)
        else $error("regulator on below supply undervoltage");

    chk_vsel_share: assert property (cfg != erc_pkg::CFG_ALONE |=> // see [RULE16]
        !drive_reg.sel_3v3)
        else $error("voltage select acted outside stand-alone");

    chk_lock_share: assert property (s_lock_share_wr |=> cfg == erc_pkg::CFG_SHARE) // see [RULE6]
        else $error("select did not lock sharing");

    chk_lock_alone: assert property (s_lock_alone_wr |=> cfg == erc_pkg::CFG_ALONE) // see [RULE1]
        else $error("enable did not lock stand-alone");

    chk_share_in_stop: assert property (ce_i && (cfg == erc_pkg::CFG_SHARE) && // see [RULE10]
        (mode_i == erc_pkg::MODE_STOP) && stp_bit && !sense_i.supply_uv |=> drive_reg.reg_on)
        else $error("sharing dropped in stop with share-in-stop set");

    chk_uv_sets: assert property (ce_i && (cfg == erc_pkg::CFG_ALONE) && // see [RULE5]
        drive_reg.reg_on && sense_i.ext_uv |=> flags[erc_pkg::EV_UV])
        else $error("undervoltage not flagged");

    // Interrupt status bits stay until the interrupt status register is read or a soft reset
    chk_irq_sticky: assert property (ce_i && !soft_reset_i && !rd_irq |=>
        (irq_stat & $past(irq_stat)) == $past(irq_stat))
        else $error("interrupt status lost before read");

    chk_ack_pulse: assert property (ce_i && wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");

endmodule

/* File: verif/erc_bench.sv */
// Self-checking testbench of the external regulator control block
module erc_bench;
    timeunit 1ns;
    timeprecision 1ps;

    logic ref_clk_i;
    logic reset_n_i = 1'b0;
    logic ce_i = 1'b1;
    logic soft_reset_i = 1'b0;
    erc_pkg::erc_mode_t mode_i = erc_pkg::MODE_NORMAL;
    erc_pkg::erc_sense_t sense_i = 3'h0;
    erc_pkg::erc_drive_t drive_o;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [3:0] wb_adr_i = 4'h0;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    logic irq_o;
    int num_errors = 0;
    int comparisons = 0;
    logic [31:0] rdat;

    erc_top u_erc_top (
        .ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .ce_i(ce_i),
        .soft_reset_i(soft_reset_i), .mode_i(mode_i), .sense_i(sense_i),
        .drive_o(drive_o), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq_o(irq_o)
    );

    initial
    begin
        ref_clk_i = 1'b0;
        forever #5 ref_clk_i = ~ref_clk_i;
    end

    // ****************************************
    // Helpers
    // ****************************************
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
        comparisons++;
        if (got !== exp)
        begin
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, msg, got, exp);
            num_errors++;
        end
    endtask

    // Classic single cycle; no fixed latency is assumed, the watchdog ends a hang
    task automatic wb(input logic we, input logic [3:0] adr, input logic [31:0] wd);
        @(posedge ref_clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_dat_i <= wd;
        wb_sel_i <= 4'hf;
        do @(posedge ref_clk_i); while (wb_ack_o !== 1'b1);
        rdat = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] adr, input logic [31:0] exp, input string msg);
        wb(1'b0, adr, 32'h0);
        check(rdat, exp, msg);
    endtask

    // Sense bits: [2] shunt limit, [1] output undervoltage, [0] supply undervoltage
    task automatic drv(input erc_pkg::erc_mode_t m, input logic [2:0] s);
        @(posedge ref_clk_i);
        mode_i <= m;
        sense_i <= erc_pkg::erc_sense_t'(s);
        repeat (3) @(posedge ref_clk_i);
    endtask

    task automatic chk_drv(input logic [2:0] exp, input string msg);
        check({29'h0, drive_o}, {29'h0, exp}, msg);
    endtask

    task automatic power_reset();
        @(posedge ref_clk_i);
        reset_n_i <= 1'b0;
        repeat (3) @(posedge ref_clk_i);
        reset_n_i <= 1'b1;
    endtask

    task automatic results();
        $display("Comparisons %0d, mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    initial
    begin
        repeat (20000) @(posedge ref_clk_i);
        num_errors++;
        results();
    end

    // ****************************************
    // Tests
    // ****************************************
    initial
    begin
        repeat (10) @(posedge ref_clk_i);
        reset_n_i <= 1'b1;
        rd(erc_pkg::OFF_CTRL, 32'h0, "ctrl reset");
        rd(erc_pkg::OFF_STAT, 32'h0, "stat reset");
        rd(erc_pkg::OFF_IRQ, 32'h0, "irq reset");
        rd(erc_pkg::OFF_MASK, 32'h0, "mask reset");
        rd(4'h2, 32'h0, "unmapped read");
        chk_drv(3'h0, "drive reset");
        $display("test reset done");

        wb(1'b1, erc_pkg::OFF_MASK, 32'h2);
        rd(erc_pkg::OFF_MASK, 32'h2, "mask rw");
        wb(1'b1, erc_pkg::OFF_CTRL, 32'h09);
        drv(erc_pkg::MODE_NORMAL, 3'h0);
        chk_drv(3'h5, "alone on at 3v3");
        rd(erc_pkg::OFF_STAT, 32'h05, "alone locked");
        wb(1'b1, erc_pkg::OFF_CTRL, 32'h02);
        drv(erc_pkg::MODE_NORMAL, 3'h0);
        rd(erc_pkg::OFF_STAT, 32'h01, "alone kept, no error");
        rd(erc_pkg::OFF_CTRL, 32'h00, "select reads clear");
        chk_drv(3'h0, "alone switched off");
        $display("test stand-alone lock done");

        wb(1'b1, erc_pkg::OFF_CTRL, 32'h01);
        drv(erc_pkg::MODE_NORMAL, 3'h4);
        chk_drv(3'h6, "limit active");
        rd(erc_pkg::OFF_STAT, 32'h55, "overcurrent set");
        check({31'h0, irq_o}, 32'h1, "irq raised");
        wb(1'b1, erc_pkg::OFF_STAT, 32'h10);
        rd(erc_pkg::OFF_STAT, 32'h55, "clear refused");
        drv(erc_pkg::MODE_NORMAL, 3'h0);
        rd(erc_pkg::OFF_STAT, 32'h15, "flag sticky");
        wb(1'b1, erc_pkg::OFF_STAT, 32'h10);
        rd(erc_pkg::OFF_STAT, 32'h05, "clear accepted");
        rd(erc_pkg::OFF_IRQ, 32'h02, "irq status");
        @(posedge ref_clk_i);
        check({31'h0, irq_o}, 32'h0, "irq cleared by read");
        $display("test overcurrent done");

        drv(erc_pkg::MODE_NORMAL, 3'h2);
        rd(erc_pkg::OFF_STAT, 32'h25, "undervoltage set");
        check({31'h0, irq_o}, 32'h0, "uv irq masked");
        rd(erc_pkg::OFF_IRQ, 32'h04, "uv irq status");
        drv(erc_pkg::MODE_NORMAL, 3'h0);
        wb(1'b1, erc_pkg::OFF_STAT, 32'h20);
        rd(erc_pkg::OFF_STAT, 32'h05, "uv cleared");
        drv(erc_pkg::MODE_NORMAL, 3'h1);
        chk_drv(3'h0, "off below supply uv");
        wb(1'b1, erc_pkg::OFF_CTRL, 32'h11);
        drv(erc_pkg::MODE_NORMAL, 3'h1);
        chk_drv(3'h4, "kept on below supply uv");
        // Stand-alone is off in init and fail-safe only
        for (int m = 0; m < 6; m++)
        begin
            drv(erc_pkg::erc_mode_t'(m), 3'h0);
            chk_drv((m == 0 || m == 5) ? 3'h0 : 3'h4, "alone by mode");
        end
        drv(erc_pkg::MODE_NORMAL, 3'h0);
        $display("test undervoltage done");

        // Soft reset clears the controls but must not open the lock
        @(posedge ref_clk_i);
        soft_reset_i <= 1'b1;
        @(posedge ref_clk_i);
        soft_reset_i <= 1'b0;
        rd(erc_pkg::OFF_STAT, 32'h01, "lock after soft reset");
        rd(erc_pkg::OFF_CTRL, 32'h00, "ctrl after soft reset");
        rd(erc_pkg::OFF_MASK, 32'h00, "mask after soft reset");
        power_reset();
        rd(erc_pkg::OFF_STAT, 32'h00, "lock released at power-up");
        $display("test soft reset done");

        // Output level matches the main regulator, so voltage select stays clear
        wb(1'b1, erc_pkg::OFF_CTRL, 32'h06);
        rd(erc_pkg::OFF_CTRL, 32'h06, "share select reads set");
        for (int m = 0; m < 6; m++)
        begin
            drv(erc_pkg::erc_mode_t'(m), 3'h0);
            chk_drv((m == 1 || m == 2) ? 3'h4 : 3'h0, "share by mode");
        end
        wb(1'b1, erc_pkg::OFF_CTRL, 32'h02);
        drv(erc_pkg::MODE_STOP, 3'h0);
        chk_drv(3'h0, "share off in stop");
        rd(erc_pkg::OFF_CTRL, 32'h02, "select stays set");
        drv(erc_pkg::MODE_NORMAL, 3'h0);
        chk_drv(3'h4, "share resumes");
        rd(erc_pkg::OFF_STAT, 32'h06, "share locked");
        // Clock enable low must hold the drive through a mode change
        ce_i <= 1'b0;
        drv(erc_pkg::MODE_STOP, 3'h0);
        chk_drv(3'h4, "frozen while disabled");
        ce_i <= 1'b1;
        drv(erc_pkg::MODE_NORMAL, 3'h0);
        chk_drv(3'h4, "running again");
        $display("test load sharing done");

        wb(1'b1, erc_pkg::OFF_CTRL, 32'h0b);
        drv(erc_pkg::MODE_STOP, 3'h0);
        chk_drv(3'h0, "enable has no effect");
        drv(erc_pkg::MODE_NORMAL, 3'h0);
        rd(erc_pkg::OFF_STAT, 32'h0e, "command error");
        wb(1'b1, erc_pkg::OFF_CTRL, 32'h08);
        rd(erc_pkg::OFF_STAT, 32'h0e, "config untouched");
        rd(erc_pkg::OFF_IRQ, 32'h01, "error irq status");
        drv(erc_pkg::MODE_NORMAL, 3'h6);
        chk_drv(3'h4, "no limit while sharing");
        rd(erc_pkg::OFF_STAT, 32'h0e, "no oc or uv flag");
        $display("test share errors done");
        results();
    end
endmodule
